// ===== rtl/serial_link_cmd_source_cfg.sv
// serial link response latency, protocol select and command source routing
// assumes an AXI4-Lite master and a framer that flags the query end
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module serial_link_cmd_source_cfg (
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // serial framer side
    input  wire logic        query_end,
    input  wire logic        reply_ready,
    output logic             reply_start,
    // protocol decode
    output logic             std_modbus_en,
    output logic             std_loader_en,
    output logic             std_general_en,
    output logic             opt_modbus_en,
    output logic             opt_general_en,
    // command source routing
    output logic             freq_from_link,
    output logic             run_from_link
);
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_wait = 3'b010,
        st_proc = 3'b100
    } lat_e;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  latency;
        logic [1:0]  std_prot;
        logic [1:0]  opt_prot;
        logic [1:0]  loader;
        lat_e        lat;
        logic [7:0]  lat_cnt;
        logic        reply_start;
        logic [4:0]  prot_en;
        logic [1:0]  route;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic   tick;
    logic   tick_clear;

    assign tick_clear = (st_r.lat != st_wait);

    // 10 ms time base, held cleared outside the wait
    tick_gen #(
        .period (link_cfg_pkg::tick_cyc)
    ) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .clear   (tick_clear),
        .tick    (tick)
    );

    always_comb begin
        logic       wr_ok;
        logic [7:0] lat_w;
        wr_ok = 1'b0;
        lat_w = 8'h00;
        st_nxt = st_r;
        st_nxt.reply_start = 1'b0;

        // write channel
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.awready = 1'b0;
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.wready = 1'b0;
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = link_cfg_pkg::resp_okay;
            wr_ok = st_r.wstrb[0];
            case (st_r.awaddr)
                link_cfg_pkg::off_latency: begin
                    lat_w = st_r.wdata[7:0];
                    // clamp to 1.00 s
                    if (wr_ok) begin
                        st_nxt.latency = (lat_w > link_cfg_pkg::latency_max)
                            ? link_cfg_pkg::latency_max : lat_w;
                    end
                end
                link_cfg_pkg::off_std_prot: begin
                    // codes 0..2 only
                    if (wr_ok && st_r.wdata[1:0] != 2'h3) begin
                        st_nxt.std_prot = st_r.wdata[1:0];
                    end
                end
                link_cfg_pkg::off_opt_prot: begin
                    // loader code refused on option port
                    if (wr_ok && (st_r.wdata[1:0] == link_cfg_pkg::prot_modbus
                        || st_r.wdata[1:0] == link_cfg_pkg::prot_general)) begin
                        st_nxt.opt_prot = st_r.wdata[1:0];
                    end
                end
                link_cfg_pkg::off_loader: begin
                    // value 3 gives the host both sources
                    if (wr_ok) begin
                        st_nxt.loader = st_r.wdata[1:0];
                    end
                end
                default: st_nxt.bresp = link_cfg_pkg::resp_slverr;
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
            st_nxt.awready = 1'b1;
            st_nxt.wready = 1'b1;
        end

        // read channel
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.arready = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = link_cfg_pkg::resp_okay;
            st_nxt.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                link_cfg_pkg::off_latency:  st_nxt.rdata[7:0] = st_r.latency;
                link_cfg_pkg::off_std_prot: st_nxt.rdata[1:0] = st_r.std_prot;
                link_cfg_pkg::off_opt_prot: st_nxt.rdata[1:0] = st_r.opt_prot;
                link_cfg_pkg::off_loader:   st_nxt.rdata[1:0] = st_r.loader;
                link_cfg_pkg::off_status: begin
                    st_nxt.rdata[2:0] = st_r.lat;
                    st_nxt.rdata[15:8] = st_r.lat_cnt;
                end
                default: st_nxt.rresp = link_cfg_pkg::resp_slverr;
            endcase
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
            st_nxt.arready = 1'b1;
        end

        // response latency sequencer
        case (st_r.lat)
            st_idle: begin
                st_nxt.lat_cnt = 8'h00;
                if (query_end) begin
                    st_nxt.lat = (st_r.latency == 8'h00) ? st_proc : st_wait;
                end
            end
            st_wait: begin
                if (tick) begin
                    st_nxt.lat_cnt = st_r.lat_cnt + 8'h01;
                    if (st_r.lat_cnt + 8'h01 >= st_r.latency) begin
                        st_nxt.lat = st_proc;
                    end
                end
            end
            st_proc: begin
                // processing time added after the latency
                if (reply_ready) begin
                    st_nxt.reply_start = 1'b1;
                    st_nxt.lat = st_idle;
                    st_nxt.lat_cnt = 8'h00;
                end
            end
            default: st_nxt.lat = st_idle;
        endcase

        // protocol decode
        st_nxt.prot_en[0] = (st_r.std_prot == link_cfg_pkg::prot_modbus);
        st_nxt.prot_en[1] = (st_r.std_prot == link_cfg_pkg::prot_loader);
        st_nxt.prot_en[2] = (st_r.std_prot == link_cfg_pkg::prot_general);
        st_nxt.prot_en[3] = (st_r.opt_prot == link_cfg_pkg::prot_modbus);
        st_nxt.prot_en[4] = (st_r.opt_prot == link_cfg_pkg::prot_general);
        // command routing
        st_nxt.route = st_r.loader;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.awready <= 1'b1;
            st_r.wready <= 1'b1;
            st_r.arready <= 1'b1;
            st_r.latency <= link_cfg_pkg::latency_rst;
            st_r.std_prot <= link_cfg_pkg::std_prot_rst;
            st_r.opt_prot <= link_cfg_pkg::opt_prot_rst;
            st_r.loader <= link_cfg_pkg::loader_rst;
            st_r.lat <= st_idle;
            st_r.prot_en <= 5'h09;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready  = st_r.awready;
    assign s_axi_wready   = st_r.wready;
    assign s_axi_bvalid   = st_r.bvalid;
    assign s_axi_bresp    = st_r.bresp;
    assign s_axi_arready  = st_r.arready;
    assign s_axi_rvalid   = st_r.rvalid;
    assign s_axi_rdata    = st_r.rdata;
    assign s_axi_rresp    = st_r.rresp;
    assign reply_start    = st_r.reply_start;
    assign std_modbus_en  = st_r.prot_en[0];
    assign std_loader_en  = st_r.prot_en[1];
    assign std_general_en = st_r.prot_en[2];
    assign opt_modbus_en  = st_r.prot_en[3];
    assign opt_general_en = st_r.prot_en[4];
    assign freq_from_link = st_r.route[0];
    assign run_from_link  = st_r.route[1];
endmodule
`default_nettype wire

// ===== common/link_cfg_pkg.sv
// package for the serial link configuration and command source block
// assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus
package link_cfg_pkg;
    // register byte offsets
    localparam logic [7:0] off_latency  = 8'h00;
    localparam logic [7:0] off_std_prot = 8'h04;
    localparam logic [7:0] off_opt_prot = 8'h08;
    localparam logic [7:0] off_loader   = 8'h0c;
    localparam logic [7:0] off_status   = 8'h10;
    // reset values
    localparam logic [7:0] latency_rst  = 8'h00;
    localparam logic [1:0] std_prot_rst = 2'h0;
    localparam logic [1:0] opt_prot_rst = 2'h0;
    localparam logic [1:0] loader_rst   = 2'h0;
    // protocol codes
    localparam logic [1:0] prot_modbus  = 2'h0;
    localparam logic [1:0] prot_loader  = 2'h1;
    localparam logic [1:0] prot_general = 2'h2;
    // latency range, in 10 ms units: 0.00 to 1.00 s
    localparam logic [7:0] latency_max  = 8'h64;
    // tick timing
    localparam int clk_mhz   = 250;
    localparam int tick_ms   = 10;
    localparam int tick_cyc  = tick_ms * 1000 * clk_mhz;
    localparam int tick_w    = 22;
    // bus response codes; slverr answers an unmapped address
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// ===== rtl/tick_gen.sv
// divider producing one-cycle ticks every period cycles
// assumes a synchronous active-low reset and a clock enable
`timescale 1ns/10ps
`default_nettype none
module tick_gen #(
    parameter int period = 2500000
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    // control
    input  wire logic clear,
    output logic      tick
);
    typedef struct packed {
        logic [link_cfg_pkg::tick_w-1:0] cnt;
        logic                            tick;
    } tick_s;
    tick_s st_r;
    tick_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (clear) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == link_cfg_pkg::tick_w'(period - 1)) begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule
`default_nettype wire

// ===== test/framer_model.sv
// far-side framer model: flags query end, builds a reply dly + 1 cycles after query_end
// assumes the bench clock and a bench-driven fire pulse
`timescale 1ns/10ps
`default_nettype none
module framer_model (
    // clock
    input  wire logic       aclk,
    // bench control
    input  wire logic       fire,
    input  wire logic [7:0] dly,
    // framer lines
    input  wire logic       reply_start,
    output logic            query_end,
    output logic            reply_ready
);
    logic [8:0] cnt;
    initial begin
        query_end = 1'b0;
        reply_ready = 1'b0;
        cnt = 9'h000;
    end
    // reply build time varies with dly
    always @(posedge aclk) begin
        query_end <= fire;
        cnt <= fire ? {1'b0, dly} + 9'h001 : (cnt != 9'h000) ? cnt - 9'h001 : cnt;
        reply_ready <= (cnt == 9'h001) || (reply_ready && !reply_start);
    end
endmodule
`default_nettype wire

// ===== test/serial_link_cmd_source_cfg_checker.sv
// port assertions for the link config block
// bound to every instance of serial_link_cmd_source_cfg
`timescale 1ns/10ps
`default_nettype none
module link_cfg_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // framer and decode
    input wire logic reply_ready,
    input wire logic reply_start,
    input wire logic std_modbus_en,
    input wire logic std_loader_en,
    input wire logic std_general_en,
    input wire logic opt_modbus_en,
    input wire logic opt_general_en,
    input wire logic freq_from_link,
    input wire logic run_from_link
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_std_onehot: assert property (
        $onehot({std_modbus_en, std_loader_en, std_general_en}))
        else $error("std decode not one-hot");
    chk_opt_onehot: assert property (
        $onehot({opt_modbus_en, opt_general_en}))
        else $error("opt decode not one-hot");
    chk_route_cause: assert property (
        $changed({freq_from_link, run_from_link}) && $past(aresetn)
        |-> $past(s_axi_bvalid)) else $error("routing moved without write");
    chk_route_volatile: assert property (disable iff (1'b0)
        !aresetn |=> (!freq_from_link && !run_from_link)
        ##1 (!freq_from_link && !run_from_link))
        else $error("routing kept over reset");
    chk_reply_cause: assert property (
        reply_start |-> $past(reply_ready)) else $error("reply too early");
    chk_reply_pulse: assert property (
        reply_start |=> !reply_start) else $error("reply start not a pulse");
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    cov_reply: cover property (reply_start);
    cov_both_link: cover property (freq_from_link && run_from_link);
    cov_loader: cover property (std_loader_en);
endmodule
bind serial_link_cmd_source_cfg link_cfg_checker chk_i (.*);
`default_nettype wire

// ===== test/serial_link_cmd_source_cfg_tb_top.sv
// self-checking bench for the link config block
// assumes framer_model on the serial side and the checker bound in
`timescale 1ns/10ps
`default_nettype none
module serial_link_cmd_source_cfg_tb_top;
    logic        aclk, aresetn, ce, fire, query_end, reply_ready, reply_start;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, dly, val, lf;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, freq_from_link, run_from_link;
    logic        std_modbus_en, std_loader_en, std_general_en;
    logic        opt_modbus_en, opt_general_en;
    logic [7:0]  sh [4];
    int          fail_count, n_compared, n;
    serial_link_cmd_source_cfg uut (.*);
    framer_model far_end (.*);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] expv(int k, logic [7:0] p, logic [7:0] v);
        case (k)
            0: return (v > 8'h64) ? 8'h64 : v;
            1: return (v[1:0] == 2'h3) ? p : {6'h00, v[1:0]};
            2: return v[0] ? p : {6'h00, v[1:0]};
            default: return {6'h00, v[1:0]};
        endcase
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w,
                      input logic [3:0] s, output logic [1:0] o);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= w;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        o = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q,
                      output logic [1:0] o);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        q = s_axi_rdata;
        o = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic query(input logic [7:0] t);
        @(posedge aclk);
        fire <= 1'b1;
        dly <= t;
        @(posedge aclk);
        fire <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        report_and_stop();
    end
    initial begin
        {aresetn, fire, dly, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_wstrb, s_axi_awaddr} = '0;
        {s_axi_araddr, s_axi_wdata} = '0;
        ce = 1'b1;
        lf = 8'h0d;
        fail_count = 0;
        n_compared = 0;
        sh = '{default: 8'h00};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h10, d, r);
        chk(d, 32'h1);
        for (int k = 0; k < 4; k++) begin
            rd(8'(4 * k), d, r);
            chk(d, 32'h0);
            for (int v = 0; v < 8; v++) begin
                lf = lfsr(lf);
                val = (v < 4) ? 8'(v) : (v < 6) ? 8'(8'h60 + v) : lf;
                wr(8'(4 * k), {24'h0, val}, 4'hf, r);
                sh[k] = expv(k, sh[k], val);
                rd(8'(4 * k), d, r);
                chk(d, {24'h0, sh[k]});
                chk({25'h0, std_modbus_en, std_loader_en, std_general_en,
                     opt_modbus_en, opt_general_en, freq_from_link,
                     run_from_link}, {25'h0, sh[1] == 8'h0, sh[1] == 8'h1,
                     sh[1] == 8'h2, sh[2] == 8'h0, sh[2] == 8'h2, sh[3][0],
                     sh[3][1]});
            end
        end
        wr(8'h00, 32'h5, 4'h0, r);
        rd(8'h00, d, r);
        chk(d, {24'h0, sh[0]});
        wr(8'h14, 32'h1, 4'hf, r);
        chk({30'h0, r}, 32'h2);
        rd(8'h14, d, r);
        chk(d, 32'h0);
        chk({30'h0, r}, 32'h2);
        wr(8'h00, 32'h0, 4'hf, r);
        for (int q = 0; q < 4; q++) begin
            lf = lfsr(lf);
            query(lf & 8'h3f);
            n = 0;
            while (reply_start !== 1'b1 && n < 300) begin
                @(posedge aclk);
                n++;
            end
            chk(32'(n < 300), 32'h1);
        end
        // a query end seen while the enable is low is not taken
        ce <= 1'b0;
        query(8'h00);
        repeat (4) @(posedge aclk);
        ce <= 1'b1;
        n = 0;
        repeat (8) begin
            @(posedge aclk);
            if (reply_start !== 1'b0) n++;
        end
        chk(n, 32'h0);
        wr(8'h00, 32'h1, 4'hf, r);
        query(8'h00);
        n = 0;
        repeat (1000) begin
            @(posedge aclk);
            if (reply_start !== 1'b0) n++;
        end
        chk(n, 32'h0);
        rd(8'h10, d, r);
        chk(d, 32'h2);
        // host takes both sources over the link
        wr(8'h0c, 32'h3, 4'hf, r);
        rd(8'h0c, d, r);
        chk(d, 32'h3);
        chk({30'h0, freq_from_link, run_from_link}, 32'h3);
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h0c, d, r);
        chk(d, 32'h0);
        chk({30'h0, freq_from_link, run_from_link}, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
